// *** hw/pwt_polling_wakeup_timer.sv ***
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "pwt_consts.svh"
module pwt_polling_wakeup_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic raw_timer_clk,
  input wire logic xo_ready,
  input wire logic power_down,
  input wire logic strap_pin_timer_default,
  input wire pwt_pkg::pwt_rx_flags_t rx_flags_in,
  output logic trimmed_timer_clk,
  output logic poll_irq,
  output logic wake_req,
  output pwt_pkg::pwt_mode_t wake_mode,
  output logic rx_launch,
  output logic rx_flags_load,
  output pwt_pkg::pwt_rx_flags_t rx_flags_out
);
  import pwt_pkg::*;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic [7:0] rd_addr;
  logic poll_timer_on;
  logic extended_range_sel;
  logic strap_done;
  logic [7:0] wakeup_interval;
  pwt_action_t wakeup_action;
  logic manual_pulse;
  logic prev_power_down;
  logic auto_pend;
  pwt_trim_t timer_trim_value;
  pwt_trim_t meas;
  pwt_acc_t acc;
  pwt_cal_state_t cal_state;
  logic [2:0] settle_cnt;
  logic raw_prev;
  logic [7:0] prescale;
  logic [7:0] count;
  logic trim_tick;

  // handshakes: each channel takes one item, response waits for both
  assign awready = !aw_full && !bvalid;
  assign wready = !w_full && !bvalid;
  assign arready = !rvalid;
  wire wr_fire = aw_full && w_full && !bvalid;
  wire wr_en = wr_fire && w_lane0;
  wire wr_ctrl = wr_en && (aw_addr == `PWT_ADDR_CTRL);
  wire wr_interval = wr_en && (aw_addr == `PWT_ADDR_INTERVAL);
  wire wr_action = wr_en && (aw_addr == `PWT_ADDR_ACTION);
  wire wr_mapped = (aw_addr == `PWT_ADDR_CTRL) || (aw_addr == `PWT_ADDR_INTERVAL)
    || (aw_addr == `PWT_ADDR_ACTION) || (aw_addr == `PWT_ADDR_STATUS);
  wire rd_fire = arvalid && arready;
  wire rd_mapped = (araddr == `PWT_ADDR_CTRL) || (araddr == `PWT_ADDR_INTERVAL)
    || (araddr == `PWT_ADDR_ACTION) || (araddr == `PWT_ADDR_STATUS);

  // read data: manual trigger reads zero, trim value has no path
  wire [31:0] rd_ctrl = {29'h0000000, extended_range_sel, 1'b0, poll_timer_on};
  wire [31:0] rd_status = {22'h000000, count, cal_state};
  wire [31:0] rd_word =
    (araddr == `PWT_ADDR_CTRL) ? rd_ctrl :
    (araddr == `PWT_ADDR_INTERVAL) ? {24'h000000, wakeup_interval} :
    (araddr == `PWT_ADDR_ACTION) ? {24'h000000, wakeup_action} :
    (araddr == `PWT_ADDR_STATUS) ? rd_status : 32'h00000000;

  // address and data holding for the write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  // write and read responses, unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `PWT_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `PWT_RESP_OKAY;
      rdata <= 32'h00000000;
      rd_addr <= 8'h00;
    end else begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rresp <= rd_mapped ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
        rdata <= rd_word;
        rd_addr <= araddr;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  wire manual_req = wr_ctrl && w_byte[`PWT_CTRL_MANUAL_BIT];

  // enable bit takes the strap level one edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poll_timer_on <= 1'b0;
      extended_range_sel <= 1'b0;
      strap_done <= 1'b0;
      wakeup_interval <= `PWT_INTERVAL_RESET;
      wakeup_action <= `PWT_ACTION_RESET;
      manual_pulse <= 1'b0;
    end else begin
      strap_done <= 1'b1;
      manual_pulse <= manual_req; // one cycle only
      if (!strap_done) begin
        poll_timer_on <= strap_pin_timer_default;
      end else if (wr_ctrl) begin
        poll_timer_on <= w_byte[`PWT_CTRL_ON_BIT];
      end
      if (wr_ctrl) begin
        extended_range_sel <= w_byte[`PWT_CTRL_EXT_BIT];
      end
      if (wr_interval) begin
        wakeup_interval <= w_byte;
      end
      if (wr_action) begin
        wakeup_action <= w_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration
  // ----------------------------------------------------------------
  wire raw_rise = raw_timer_clk && !raw_prev;
  wire settled = (settle_cnt == `PWT_SETTLE_EDGES);
  wire xo_lost = !poll_timer_on || !xo_ready || power_down;
  // manual request only counts while timer and crystal both run
  wire manual_ok = manual_pulse && poll_timer_on && xo_ready;
  wire auto_ok = auto_pend && poll_timer_on && xo_ready;
  wire cal_start = (cal_state == PWT_CAL_IDLE) && (manual_ok || auto_ok);
  wire meas_full = (meas == pwt_trim_t'(`PWT_TICK_CYC - 1));
  wire cal_done = (cal_state == PWT_CAL_MEASURE) && raw_rise && !xo_lost;
  pwt_cal_state_t next_cal_state;

  // measure walks settle, arm on an edge, then count to the next edge
  always_comb begin
    next_cal_state = cal_state;
    unique case (cal_state)
      PWT_CAL_IDLE: if (cal_start) next_cal_state = PWT_CAL_SETTLE;
      PWT_CAL_SETTLE: if (settled) next_cal_state = PWT_CAL_ARM;
      PWT_CAL_ARM: if (raw_rise) next_cal_state = PWT_CAL_MEASURE;
      PWT_CAL_MEASURE: if (raw_rise || meas_full) next_cal_state = PWT_CAL_IDLE;
    endcase
    if (xo_lost) begin
      next_cal_state = PWT_CAL_IDLE; // abort keeps the old trim
    end
  end

  // raw edge sampling, settle count and auto trigger latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_prev <= 1'b1; // a raw level already high after reset is no edge
      settle_cnt <= 3'h0;
      prev_power_down <= 1'b0;
      auto_pend <= 1'b0;
      cal_state <= PWT_CAL_IDLE;
    end else begin
      raw_prev <= raw_timer_clk;
      prev_power_down <= power_down;
      cal_state <= next_cal_state;
      if (!poll_timer_on) begin
        settle_cnt <= 3'h0;
      end else if (raw_rise && !settled) begin
        settle_cnt <= settle_cnt + 3'h1;
      end
      if (power_down) begin
        auto_pend <= 1'b0;
      end else if (prev_power_down) begin
        auto_pend <= 1'b1;
      end else if (cal_start) begin
        auto_pend <= 1'b0;
      end
    end
  end

  // period counter and trim register, reset loads nominal period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas <= pwt_trim_t'(0);
      timer_trim_value <= pwt_trim_t'(`PWT_TRIM_NOMINAL_CYC);
    end else begin
      if (cal_state != PWT_CAL_MEASURE) begin
        meas <= pwt_trim_t'(1);
      end else if (!meas_full) begin
        meas <= meas + pwt_trim_t'(1);
      end
      if (cal_done) begin
        timer_trim_value <= meas; // only a whole period is stored
      end
    end
  end

  // ----------------------------------------------------------------
  // trimmed tick and wakeup counter
  // ----------------------------------------------------------------
  // each raw edge adds its period; every 62.5 us of it makes a tick
  wire pwt_acc_t acc_sum = acc + pwt_acc_t'(timer_trim_value);
  wire acc_wrap = acc_sum >= pwt_acc_t'(`PWT_TICK_CYC);
  assign trim_tick = poll_timer_on && raw_rise && acc_wrap;
  wire wake_tick = trim_tick && (!extended_range_sel || prescale == `PWT_EXT_PRESCALE);
  wire low_rewrite = wr_interval && (w_byte < count);
  wire wake_evt = poll_timer_on && !low_rewrite && wake_tick && (count >= wakeup_interval);

  // modulo accumulator and extended range prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= pwt_acc_t'(0);
      prescale <= 8'h00;
      trimmed_timer_clk <= 1'b0;
    end else begin
      trimmed_timer_clk <= trim_tick;
      if (!poll_timer_on) begin
        acc <= pwt_acc_t'(0);
      end else if (raw_rise) begin
        acc <= acc_wrap ? acc_sum - pwt_acc_t'(`PWT_TICK_CYC) : acc_sum;
      end
      if (!poll_timer_on || !extended_range_sel) begin
        prescale <= 8'h00;
      end else if (trim_tick) begin
        prescale <= prescale + 8'h01;
      end
    end
  end

  // counter runs 0..interval, so a period is interval plus one ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
    end else if (!poll_timer_on || low_rewrite) begin
      count <= 8'h00;
    end else if (wake_evt) begin
      count <= 8'h00;
    end else if (wake_tick) begin
      count <= count + 8'h01; // higher rewrite just keeps counting
    end
  end

  // ----------------------------------------------------------------
  // wakeup actions
  // ----------------------------------------------------------------
  wire goes_awake = (wakeup_action.mode == PWT_MODE_STANDBY)
    || (wakeup_action.mode == PWT_MODE_RX);
  wire goes_rx = (wakeup_action.mode == PWT_MODE_RX);
  // receive flags either kept or loaded from the action fields
  wire pwt_rx_flags_t flags_new = wakeup_action.overwrite ?
    pwt_rx_flags_t'{flag_gain_b: wakeup_action.gain[1], flag_gain_a: wakeup_action.gain[0],
      flag_sub_marker: 1'b1, flag_cmd_kind: wakeup_action.cmd_kind,
      flag_chan_sel_b: wakeup_action.wakeup_chan_sel[1],
      flag_chan_sel_a: wakeup_action.wakeup_chan_sel[0]} : rx_flags_in;

  // event pulses, each one cycle after the counter expires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poll_irq <= 1'b0;
      wake_req <= 1'b0;
      wake_mode <= PWT_MODE_SLEEP;
      rx_launch <= 1'b0;
      rx_flags_load <= 1'b0;
      rx_flags_out <= '0;
    end else begin
      poll_irq <= wake_evt;
      wake_req <= wake_evt && goes_awake;
      rx_launch <= wake_evt && goes_rx;
      rx_flags_load <= wake_evt && goes_rx && wakeup_action.overwrite;
      if (wake_evt) begin
        wake_mode <= wakeup_action.mode;
        rx_flags_out <= flags_new;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_irq_every_event: assert property (
    @(posedge aclk) disable iff (!aresetn) wake_evt |=> poll_irq ##1 !poll_irq)
    else $error("event without a one-cycle interrupt pulse");
  a_rx_auto_launch: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wake_evt && wakeup_action.mode == PWT_MODE_RX |=> rx_launch && wake_req)
    else $error("receive mode event did not launch receive");
  a_trim_in_range: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer_trim_value < pwt_trim_t'(`PWT_TICK_CYC))
    else $error("trim value outside the tick period");
  a_trim_reset_nominal: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> timer_trim_value == pwt_trim_t'(`PWT_TRIM_NOMINAL_CYC))
    else $error("trim value not nominal after reset");
  a_strap_loads_enable: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(strap_done) |-> poll_timer_on == $past(strap_pin_timer_default))
    else $error("enable bit did not take the strap level");
  a_manual_reads_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rvalid && rd_addr == `PWT_ADDR_CTRL |-> !rdata[`PWT_CTRL_MANUAL_BIT])
    else $error("manual trigger bit read back as one");
  a_manual_discarded: assert property (
    @(posedge aclk) disable iff (!aresetn)
    manual_pulse && !xo_ready && !auto_pend && cal_state == PWT_CAL_IDLE
    |=> cal_state == PWT_CAL_IDLE)
    else $error("manual calibration ran without crystal");
  a_cal_after_settle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cal_state == PWT_CAL_ARM |-> settled)
    else $error("calibration armed before oscillator settled");
  a_abort_keeps_trim: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cal_state == PWT_CAL_MEASURE && xo_lost |=> $stable(timer_trim_value))
    else $error("aborted calibration changed the trim value");
  a_low_rewrite_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    low_rewrite |=> count == 8'h00 && !poll_irq)
    else $error("lower interval did not clear the counter");
  a_event_at_interval: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wake_evt |-> count >= wakeup_interval ##1 count == 8'h00)
    else $error("event away from the interval or counter kept");
  a_overwrite_marker: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wake_evt && wakeup_action.overwrite |=> rx_flags_out.flag_sub_marker)
    else $error("overwritten flags without sub-command marker");
endmodule

// *** hw/pwt_consts.svh ***
// How it works
// - every counter overflow pulses the interrupt request, whatever action is set
// - an event may leave power-down and launch a receive command
// - raw oscillator nominal period is 40 us and is never trusted directly
// - calibration measures one raw period and steers a 62.5 us modulo tick
// - timer enable bit loads from the strap pin after reset
// - trim value resets to its nominal value
// - leaving power-down triggers calibration once the crystal is ready
// - manual trigger bit writes a one-cycle pulse and always reads zero
// - manual trigger is discarded unless timer and crystal both run
// - calibration waits until the raw oscillator has settled
// - trim value stays valid, also when calibration aborts
// - trim value has no software read or write path
// - wakeup interval is interval register plus one ticks
// - range bit picks normal or extended tick resolution
// - raising the interval above the count continues the running period
// - lowering the interval below the count clears the counter at once
// - fractional modulo tick keeps long intervals within one percent
// - two-bit mode field picks the state entered after an event
// - action fields mirror channel, command kind and gain receive flags
// - overwrite bit chooses stored flags or action fields for the command
// - overwriting flags forces the sub-command marker to one
`ifndef PWT_CONSTS_SVH
`define PWT_CONSTS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PWT_ADDR_CTRL 8'h00
`define PWT_ADDR_INTERVAL 8'h04
`define PWT_ADDR_ACTION 8'h08
`define PWT_ADDR_STATUS 8'h0C
`define PWT_CTRL_ON_BIT 0
`define PWT_CTRL_MANUAL_BIT 1
`define PWT_CTRL_EXT_BIT 2
`define PWT_INTERVAL_RESET 8'h00
`define PWT_ACTION_RESET 8'h00
`define PWT_RESP_OKAY 2'h0
`define PWT_RESP_SLVERR 2'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PWT_CLK_PERIOD_NS 100
`define PWT_RAW_NOMINAL_NS 40000
`define PWT_TRIM_PERIOD_NS 62500
`define PWT_TRIM_NOMINAL_CYC ((`PWT_RAW_NOMINAL_NS) / (`PWT_CLK_PERIOD_NS))
`define PWT_TICK_CYC ((`PWT_TRIM_PERIOD_NS) / (`PWT_CLK_PERIOD_NS))
`define PWT_SETTLE_EDGES 3'h4
`define PWT_EXT_PRESCALE 8'hFF
`endif

// *** hw/pwt_pkg.sv ***
package pwt_pkg;
  typedef logic [9:0] pwt_trim_t;
  typedef logic [10:0] pwt_acc_t;
  typedef enum logic [1:0] {
    PWT_MODE_SLEEP = 2'h0,
    PWT_MODE_STANDBY = 2'h1,
    PWT_MODE_RX = 2'h2,
    PWT_MODE_HOLD = 2'h3
  } pwt_mode_t;
  typedef struct packed {
    logic overwrite;
    logic [1:0] gain;
    logic cmd_kind;
    logic [1:0] wakeup_chan_sel;
    pwt_mode_t mode;
  } pwt_action_t;
  typedef struct packed {
    logic flag_gain_b;
    logic flag_gain_a;
    logic flag_sub_marker;
    logic flag_cmd_kind;
    logic flag_chan_sel_b;
    logic flag_chan_sel_a;
  } pwt_rx_flags_t;
  typedef enum logic [1:0] {
    PWT_CAL_IDLE = 2'h0,
    PWT_CAL_SETTLE = 2'h1,
    PWT_CAL_ARM = 2'h3,
    PWT_CAL_MEASURE = 2'h2
  } pwt_cal_state_t;
endpackage

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "pwt_consts.svh"
module tb;
  import pwt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic awready;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic wready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic bvalid;
  logic bready = 1'b0;
  logic [1:0] bresp;
  logic arvalid = 1'b0;
  logic arready;
  logic [7:0] araddr = 8'h00;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic raw_timer_clk = 1'b0;
  logic xo_ready = 1'b1;
  logic power_down = 1'b0;
  logic strap_pin_timer_default = 1'b1;
  pwt_rx_flags_t rx_flags_in = 6'h00;
  logic trimmed_timer_clk;
  logic poll_irq;
  logic wake_req;
  pwt_mode_t wake_mode;
  logic rx_launch;
  logic rx_flags_load;
  pwt_rx_flags_t rx_flags_out;
  int raw_cnt = 0;
  int raw_per = 400;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  int k;
  logic [7:0] iv;
  logic [7:0] act;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;

  pwt_polling_wakeup_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .raw_timer_clk(raw_timer_clk), .xo_ready(xo_ready), .power_down(power_down),
    .strap_pin_timer_default(strap_pin_timer_default), .rx_flags_in(rx_flags_in),
    .trimmed_timer_clk(trimmed_timer_clk), .poll_irq(poll_irq), .wake_req(wake_req),
    .wake_mode(wake_mode), .rx_launch(rx_launch), .rx_flags_load(rx_flags_load),
    .rx_flags_out(rx_flags_out)
  );

  // ----------------------------------------------------------------
  // clock, raw oscillator and watchdog
  // ----------------------------------------------------------------
  always #50 aclk = ~aclk;

  // raw oscillator with a period of raw_per aclk cycles
  always @(posedge aclk) begin
    raw_cnt <= (raw_cnt >= raw_per - 1) ? 0 : raw_cnt + 1;
    raw_timer_clk <= (raw_cnt < raw_per / 2);
  end

  // cuts a hang short, only about a quarter above the expected run length of roughly 80000 cycles
  initial begin
    repeat (99000) @(posedge aclk);
    mismatches++;
    conclude();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // write address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  // counts trimmed ticks up to and including the next wakeup event
  task automatic wait_irq(output int t);
    t = 0;
    do begin
      @(posedge aclk);
      t += (trimmed_timer_clk === 1'b1);
    end while (poll_irq !== 1'b1);
  endtask

  // runs for c trimmed ticks, counting wakeup events
  task automatic run_ticks(input int c, output int irqs);
    int t;
    t = 0;
    irqs = 0;
    while (t < c) begin
      @(posedge aclk);
      t += (trimmed_timer_clk === 1'b1);
      irqs += (poll_irq === 1'b1);
    end
  endtask

  // counts trimmed ticks over a window of c clock cycles
  task automatic run_cycles(input int c, output int t);
    t = 0;
    repeat (c) begin
      @(posedge aclk);
      t += (trimmed_timer_clk === 1'b1);
    end
  endtask

  // receive flags expected on an automatic receive command
  function automatic pwt_rx_flags_t exp_flags(input logic [7:0] a, input pwt_rx_flags_t cur);
    exp_flags = a[7] ? {a[6], a[5], 1'b1, a[4], a[3], a[2]} : cur;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h6c98d7b6));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`PWT_ADDR_CTRL);
    chk(rd_data, 32'h00000001);
    axi_rd(`PWT_ADDR_INTERVAL);
    chk(rd_data, 32'h00000000);
    axi_rd(`PWT_ADDR_ACTION);
    chk(rd_data, 32'h00000000);
    axi_rd(8'h10);
    chk(rd_resp, `PWT_RESP_SLVERR);
    axi_wr(8'h10, 32'h000000FF);
    chk(wr_resp, `PWT_RESP_SLVERR);
    // every mode, then receive mode with and without overwrite
    for (int i = 0; i < 6; i++) begin
      iv = (i == 0) ? 8'h00 : 8'($urandom_range(2, 0));
      act = 8'($urandom);
      act[1:0] = (i < 4) ? 2'(i) : 2'h2;
      if (i >= 4) act[7] = i[0];
      rx_flags_in <= 6'($urandom);
      axi_wr(`PWT_ADDR_INTERVAL, {24'h000000, iv});
      axi_wr(`PWT_ADDR_ACTION, {24'h000000, act});
      wait_irq(n);
      wait_irq(n);
      chk(n, 32'(iv) + 1);
      chk(wake_req, (act[1:0] == 2'h1 || act[1:0] == 2'h2));
      chk(wake_mode, act[1:0]);
      chk(rx_launch, (act[1:0] == 2'h2));
      chk(rx_flags_load, (act[1:0] == 2'h2 && act[7]));
      if (act[1:0] == 2'h2) chk(rx_flags_out, exp_flags(act, rx_flags_in));
    end
    // interval rewritten above, then below the running count
    axi_wr(`PWT_ADDR_INTERVAL, 32'h0000000C);
    wait_irq(n);
    run_ticks(4, k);
    axi_wr(`PWT_ADDR_INTERVAL, 32'h00000008);
    wait_irq(n);
    chk(n + 4, 9);
    axi_wr(`PWT_ADDR_INTERVAL, 32'h0000000C);
    run_ticks(7, k);
    axi_wr(`PWT_ADDR_INTERVAL, 32'h00000002);
    axi_rd(`PWT_ADDR_STATUS);
    chk(rd_data[9:2], 8'h00);
    wait_irq(n);
    chk(n, 3);
    // extended range: no event within a few trimmed ticks
    axi_wr(`PWT_ADDR_CTRL, 32'h00000005);
    axi_wr(`PWT_ADDR_INTERVAL, 32'h00000000);
    run_ticks(8, k);
    chk(k, 0);
    axi_wr(`PWT_ADDR_CTRL, 32'h00000001);
    // leaving power-down recalibrates against a slower raw clock
    raw_per = 500;
    power_down <= 1'b1;
    repeat (5) @(posedge aclk);
    power_down <= 1'b0;
    repeat (2) @(posedge aclk);
    axi_rd(`PWT_ADDR_STATUS);
    chk(rd_data[1:0] != 2'h0, 1);
    repeat (4000) @(posedge aclk);
    run_cycles(10000, n);
    chk(n >= 15 && n <= 17, 1);
    // manual trigger refused with crystal stopped or timer off
    xo_ready <= 1'b0;
    axi_wr(`PWT_ADDR_CTRL, 32'h00000003);
    axi_rd(`PWT_ADDR_STATUS);
    chk(rd_data[1:0], 2'h0);
    xo_ready <= 1'b1;
    // a refused request must not linger until the crystal returns
    axi_rd(`PWT_ADDR_STATUS);
    chk(rd_data[1:0], 2'h0);
    axi_wr(`PWT_ADDR_CTRL, 32'h00000000);
    axi_wr(`PWT_ADDR_CTRL, 32'h00000002);
    axi_rd(`PWT_ADDR_STATUS);
    chk(rd_data[1:0], 2'h0);
    // enabling and triggering stay in separate writes
    axi_wr(`PWT_ADDR_CTRL, 32'h00000001);
    raw_per = 320;
    axi_wr(`PWT_ADDR_CTRL, 32'h00000003);
    axi_rd(`PWT_ADDR_STATUS);
    chk(rd_data[1:0] != 2'h0, 1);
    axi_rd(`PWT_ADDR_CTRL);
    chk(rd_data, 32'h00000001);
    repeat (4000) @(posedge aclk);
    run_cycles(10000, n);
    chk(n >= 15 && n <= 17, 1);
    // timer off stops all ticks
    axi_wr(`PWT_ADDR_CTRL, 32'h00000000);
    run_cycles(2000, n);
    chk(n, 0);
    // mid-run reset with the strap low: timer off, trim back to nominal
    strap_pin_timer_default <= 1'b0;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`PWT_ADDR_CTRL);
    chk(rd_data, 32'h00000000);
    raw_per = 400;
    axi_wr(`PWT_ADDR_CTRL, 32'h00000001);
    repeat (1000) @(posedge aclk);
    run_cycles(10000, n);
    chk(n >= 15 && n <= 17, 1);
    conclude();
  end
endmodule
